// ---- core/ehw_pkg.sv ----
// constants shared by the event, hold and wake-up control block
// assumes a single 50 MHz system clock and an 8-bit event map
package ehw_pkg;
	// event map positions, shared by flags, enables and hold enables
	localparam int EV_W = 8;
	localparam int EV_DIV0 = 0;
	localparam int EV_TM0 = 1;
	localparam int EV_PORT = 2;
	localparam int EV_DIV1 = 4;
	localparam int EV_TM1 = 7;
	localparam logic [7:0] EV_VALID = 8'h97;
	// cause map: timer 1 moves down to bit 5
	localparam int HC_TM1 = 5;
	localparam logic [7:0] HC_VALID = 8'h37;
	// change-input port
	localparam int PIN_W = 4;
	localparam int PM_PULLUP = 2;
	// program addresses
	localparam int PC_W = 12;
	localparam logic [11:0] PC_RESET_ADDR = 12'h000;
	localparam logic [11:0] VEC_BASE = 12'h004;
	localparam int VEC_SHIFT = 2;
	// reset values
	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam logic [3:0] REG4_RESET = 4'h0;
	localparam logic [2:0] IDX_RESET = 3'h0;
	// operating state of the core as seen by this block
	typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_HOLD_ISR, ST_STOP} ehw_mode_t;
endpackage

// ---- core/ehw_sync.sv ----
// two-flop synchroniser for pins entering the system clock domain
// assumes reset is synchronous and active high at this level
`timescale 1ns/1ps
module ehw_sync #(
	parameter int W = 4,
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin side and clock side
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= {W{RST_VAL}};
			q <= {W{RST_VAL}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // ehw_sync

// ---- core/ehw_pick.sv ----
// lowest-bit priority picker for pending interrupt sources
// assumes the request vector comes from logic on the same clock
`timescale 1ns/1ps
module ehw_pick #(
	parameter int W = 8
) (
	// requests in
	input wire logic [W-1:0] req,
	// winner out
	output logic any,
	output logic [$clog2(W)-1:0] idx,
	output logic [W-1:0] onehot
);
	// lowest set bit wins
	always_comb begin
		idx = '0;
		for (int i = W - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = i[$clog2(W)-1:0];
			end
		end
	end

	// one-hot of the winner, zero when idle
	assign any = |req;
	assign onehot = any ? (W'(1) << idx) : '0;
endmodule // ehw_pick

// ---- core/ehw_ctrl.sv ----
// event flags, interrupt gating, hold release and stop wake-up control
// assumes the core issues one-cycle instruction strobes on CLK and
// the timer and divider events are one-cycle pulses on CLK
// Functional notes
// R1: write-only 8-bit interrupt enables; bits 0,1,2,4,7 used, 3,5,6 reserved.
// R2: taking an interrupt clears only that source's event flag.
// R3: after a take, no interrupt until enables rewritten or unmask executed.
// R4: mask instruction stops every interrupt whatever the enables hold.
// R5: 4-bit port enables gate each change pin for hold release or interrupt.
// R6: hardware loads 8-bit cause register; bits 0,1,2,4,5 used.
// R7: cause register read as low nibble and high nibble separately.
// R8: any cause bit set leaves hold and makes hold instruction void.
// R9: a cause bit clears once its event flag and hold enable both clear.
// R10: hardware sets 8-bit event flags; bits 0,1,2,4,7 used.
// R11: event flags clear by the clear instruction operand or on interrupt.
// R12: reset comes from power-on reset or the external low-active pin.
// R13: reset loads address 000H and clears all flag and enable registers.
// R14: change port pull-ups are off after reset.
// R15: mode bit 2 turns the change port pull-ups on.
// R16: port, hold and interrupt enables together let a change wake or interrupt.
// R17: change status records per-pin changes, readable and clearable.
// R18: falling edge on a stop-wake enabled pin ends stop mode.
// R19: interrupt needs a set event flag plus its enable, port enables too.
// R20: write-only 8-bit hold enables pick which events release hold.
// R21: interrupt in hold runs its routine then hold resumes after return.
// R22: each source jumps to its own address from 004H to 020H.
// R23: change pins pass two flops before any edge detection.
// R24: lowest pending enabled flag is served first, others stay pending.
`timescale 1ns/1ps
module ehw_ctrl (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic EXT_RESET_N,
	// register writes from the core
	input wire logic [7:0] WR_DATA,
	input wire logic INT_EN_WR,
	input wire logic HOLD_EN_WR,
	input wire logic PORT_EN_WR,
	input wire logic STOP_EN_WR,
	input wire logic MODE_WR,
	// instruction strobes from the core
	input wire logic EVT_CLR_OP,
	input wire logic CHG_CLR_OP,
	input wire logic INT_UNMASK_OP,
	input wire logic INT_MASK_OP,
	input wire logic HOLD_OP,
	input wire logic STOP_OP,
	input wire logic RETURN_OP,
	// register reads
	input wire logic CAUSE_LO_RD,
	input wire logic CAUSE_HI_RD,
	input wire logic CHG_STAT_RD,
	output logic [3:0] RD_DATA,
	// event sources
	input wire logic DIV0_OVF,
	input wire logic TM0_UDF,
	input wire logic DIV1_OVF,
	input wire logic TM1_UDF,
	input wire logic [3:0] CHANGE_IN,
	// control back to the core and pads
	output logic INT_TAKE,
	output logic PC_LOAD,
	output logic [11:0] PC_ADDR,
	output logic IN_HOLD,
	output logic IN_STOP,
	output logic [3:0] PULLUP_EN
);
	logic ext_ok;
	logic rst;
	logic [3:0] pin_q;
	logic [3:0] pin_prev;
	logic [3:0] chg;
	logic [3:0] fall;
	logic [7:0] interrupt_enable_flags;
	logic [7:0] hold_release_enable;
	logic [3:0] port_change_enable;
	logic [3:0] stop_wake_enable;
	logic [3:0] port_structure_mode;
	logic [7:0] event_flags;
	logic [7:0] hold_release_cause;
	logic [3:0] port_change_status;
	logic [7:0] evt_set;
	logic [7:0] evt_clr;
	logic [7:0] pending;
	logic [7:0] win;
	logic win_any;
	logic [2:0] win_idx;
	logic [2:0] take_idx;
	logic blocked;
	logic masked;
	logic take;
	logic after_rst;
	ehw_pkg::ehw_mode_t state;
	ehw_pkg::ehw_mode_t next_state;

	// map event positions onto cause positions
	function automatic logic [7:0] to_cause(input logic [7:0] e);
		logic [7:0] c;
		c = e & ehw_pkg::EV_VALID;
		c[ehw_pkg::HC_TM1] = e[ehw_pkg::EV_TM1];
		c[ehw_pkg::EV_TM1] = 1'b0;
		return c & ehw_pkg::HC_VALID;
	endfunction

	// external reset pin is asynchronous, so synchronise it first
	ehw_sync #(.W(1), .RST_VAL(1'b0)) u_ext_sync (
		.clk(CLK),
		.rst(!RESET_N),
		.d(EXT_RESET_N),
		.q(ext_ok)
	);
	assign rst = !RESET_N || !ext_ok; // R12

	// change pins through two flops before edge logic; never reset, so the
	// flops and the previous level already match the pins when reset ends
	ehw_sync #(.W(ehw_pkg::PIN_W), .RST_VAL(1'b0)) u_pin_sync (
		.clk(CLK),
		.rst(1'b0),
		.d(CHANGE_IN),
		.q(pin_q)
	); // R23

	// previous pin level; tracks during reset to avoid a false change
	always_ff @(posedge CLK) begin
		pin_prev <= pin_q;
	end
	assign chg = pin_q ^ pin_prev; // R23
	assign fall = pin_prev & ~pin_q; // R18

	// write-only enable and mode registers
	always_ff @(posedge CLK) begin
		if (rst) begin
			interrupt_enable_flags <= ehw_pkg::REG8_RESET; // R13
			hold_release_enable <= ehw_pkg::REG8_RESET; // R13
			port_change_enable <= ehw_pkg::REG4_RESET; // R13
			stop_wake_enable <= ehw_pkg::REG4_RESET; // R13
			port_structure_mode <= ehw_pkg::REG4_RESET; // R14
		end else begin
			if (INT_EN_WR) interrupt_enable_flags <= WR_DATA & ehw_pkg::EV_VALID; // R1
			if (HOLD_EN_WR) hold_release_enable <= WR_DATA & ehw_pkg::EV_VALID; // R20
			if (PORT_EN_WR) port_change_enable <= WR_DATA[3:0]; // R5
			if (STOP_EN_WR) stop_wake_enable <= WR_DATA[3:0];
			if (MODE_WR) port_structure_mode <= WR_DATA[3:0];
		end
	end
	assign PULLUP_EN = {ehw_pkg::PIN_W{port_structure_mode[ehw_pkg::PM_PULLUP]}}; // R15

	// hardware events; port event only from enabled pins
	always_comb begin
		evt_set = ehw_pkg::REG8_RESET;
		evt_set[ehw_pkg::EV_DIV0] = DIV0_OVF;
		evt_set[ehw_pkg::EV_TM0] = TM0_UDF;
		evt_set[ehw_pkg::EV_PORT] = |(chg & port_change_enable); // R5
		evt_set[ehw_pkg::EV_DIV1] = DIV1_OVF;
		evt_set[ehw_pkg::EV_TM1] = TM1_UDF;
	end

	// clears from the clear instruction operand and the taken source
	assign evt_clr = (EVT_CLR_OP ? WR_DATA : ehw_pkg::REG8_RESET) | (take ? win : 8'h00); // R11 R2

	// event flags; a set in the clearing cycle wins
	always_ff @(posedge CLK) begin
		if (rst) begin
			event_flags <= ehw_pkg::REG8_RESET; // R13
		end else begin
			event_flags <= ((event_flags & ~evt_clr) | evt_set) & ehw_pkg::EV_VALID; // R10
		end
	end

	// cause bits load from flag and hold enable, drop when both are clear
	always_ff @(posedge CLK) begin
		if (rst) begin
			hold_release_cause <= ehw_pkg::REG8_RESET; // R13
		end else begin
			hold_release_cause <= (hold_release_cause
				& to_cause(event_flags | hold_release_enable)) // R9
				| to_cause(event_flags & hold_release_enable); // R6
		end
	end

	// per-pin change record; new change beats the clear
	always_ff @(posedge CLK) begin
		if (rst) begin
			port_change_status <= ehw_pkg::REG4_RESET; // R13
		end else begin
			port_change_status <= (CHG_CLR_OP ? ehw_pkg::REG4_RESET : port_change_status)
				| chg; // R17
		end
	end

	// read data held in a register
	always_ff @(posedge CLK) begin
		if (rst) begin
			RD_DATA <= ehw_pkg::REG4_RESET;
		end else if (CAUSE_LO_RD) begin
			RD_DATA <= hold_release_cause[3:0]; // R7
		end else if (CAUSE_HI_RD) begin
			RD_DATA <= hold_release_cause[7:4]; // R7
		end else if (CHG_STAT_RD) begin
			RD_DATA <= port_change_status; // R17
		end
	end

	// enabled pending sources; port source also needs a port enable
	assign pending = event_flags & interrupt_enable_flags
		& {8{1'b1}} & ~(8'(~|port_change_enable) << ehw_pkg::EV_PORT); // R19 R16

	ehw_pick #(.W(ehw_pkg::EV_W)) u_pick (
		.req(pending),
		.any(win_any),
		.idx(win_idx),
		.onehot(win)
	); // R24

	assign take = win_any && !blocked && !masked && state != ehw_pkg::ST_STOP; // R3 R4

	// block after a take, mask and unmask by instruction
	always_ff @(posedge CLK) begin
		if (rst) begin
			blocked <= 1'b0;
			masked <= 1'b0;
		end else begin
			if (take) blocked <= 1'b1; // R3
			else if (INT_EN_WR || INT_UNMASK_OP) blocked <= 1'b0; // R3
			if (INT_MASK_OP) masked <= 1'b1; // R4
			else if (INT_UNMASK_OP) masked <= 1'b0;
		end
	end

	// program address: reset address, then the vector of each take
	always_ff @(posedge CLK) begin
		if (rst) begin
			PC_ADDR <= ehw_pkg::PC_RESET_ADDR; // R13
			take_idx <= ehw_pkg::IDX_RESET;
			INT_TAKE <= 1'b0;
			after_rst <= 1'b1;
		end else begin
			INT_TAKE <= take;
			after_rst <= 1'b0;
			if (take) begin
				take_idx <= win_idx;
				PC_ADDR <= ehw_pkg::VEC_BASE
					+ (ehw_pkg::PC_W'(win_idx) << ehw_pkg::VEC_SHIFT); // R22
			end
		end
	end
	assign PC_LOAD = INT_TAKE || after_rst;

	// hold and stop sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			ehw_pkg::ST_RUN: begin
				if (STOP_OP) next_state = ehw_pkg::ST_STOP;
				else if (HOLD_OP && hold_release_cause == 8'h00) next_state = ehw_pkg::ST_HOLD; // R8
			end
			ehw_pkg::ST_HOLD: begin
				if (hold_release_cause != 8'h00) next_state = ehw_pkg::ST_RUN; // R8
				else if (take) next_state = ehw_pkg::ST_HOLD_ISR; // R21
			end
			ehw_pkg::ST_HOLD_ISR: begin
				if (RETURN_OP) begin
					next_state = (hold_release_cause == 8'h00) ? ehw_pkg::ST_HOLD
						: ehw_pkg::ST_RUN; // R21
				end
			end
			ehw_pkg::ST_STOP: begin
				if ((fall & stop_wake_enable) != 4'h0) next_state = ehw_pkg::ST_RUN; // R18
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK) begin
		if (rst) state <= ehw_pkg::ST_RUN;
		else state <= next_state;
	end
	assign IN_HOLD = state == ehw_pkg::ST_HOLD;
	assign IN_STOP = state == ehw_pkg::ST_STOP;

	// checks on the control behaviour
	default clocking cb @(posedge CLK); endclocking
	default disable iff (rst);

	a_vector_addr: assert property (INT_TAKE |-> PC_ADDR == 12'h004 + (12'(take_idx) << 2)) // R22
		else $error("vector address wrong for taken source");
	a_take_blocks: assert property (blocked && !INT_EN_WR && !INT_UNMASK_OP |=> !INT_TAKE) // R3
		else $error("interrupt taken while blocked");
	a_mask_blocks: assert property (masked && !INT_UNMASK_OP |=> !INT_TAKE) // R4
		else $error("interrupt taken while masked");
	a_take_enabled: assert property (INT_TAKE |-> $past(pending[win_idx] && !blocked && !masked)) // R19
		else $error("interrupt without enabled flag");
	a_lowest_first: assert property (take |-> (pending & (win - 8'h01)) == 8'h00 && pending[win_idx]) // R24
		else $error("not the lowest pending source");
	a_flag_cleared: assert property (take && !evt_set[win_idx] |=> !event_flags[$past(win_idx)]) // R2
		else $error("taken flag not cleared");
	a_others_kept: assert property (take && !EVT_CLR_OP |=> (event_flags & ~$past(win)) == ($past(event_flags | evt_set) & ~$past(win) & ehw_pkg::EV_VALID)) // R2
		else $error("other flags disturbed by a take");
	a_clear_op: assert property (EVT_CLR_OP |=> (event_flags & $past(WR_DATA) & ~$past(evt_set)) == 8'h00) // R11
		else $error("clear instruction left a flag");
	a_cause_drop: assert property (1'b1 |=> (hold_release_cause & ~to_cause($past(event_flags | hold_release_enable))) == 8'h00) // R9
		else $error("cause bit kept after flag and enable cleared");
	a_hold_void: assert property (state == ehw_pkg::ST_RUN && HOLD_OP && hold_release_cause != 8'h00 |=> !IN_HOLD) // R8
		else $error("hold entered with a cause set");
	a_hold_release: assert property (IN_HOLD && hold_release_cause != 8'h00 |=> state == ehw_pkg::ST_RUN) // R8
		else $error("hold not released by cause");
	a_hold_resume: assert property (state == ehw_pkg::ST_HOLD_ISR && RETURN_OP && hold_release_cause == 8'h00 |=> IN_HOLD) // R21
		else $error("hold not resumed after return");
	a_stop_wake: assert property (IN_STOP && (fall & stop_wake_enable) != 4'h0 |=> !IN_STOP) // R18
		else $error("stop not ended by enabled falling edge");
	a_change_seen: assert property (chg != 4'h0 |=> (port_change_status & $past(chg)) == $past(chg)) // R17
		else $error("pin change not recorded");
	a_pullup_mode: assert property (MODE_WR |=> PULLUP_EN[0] == $past(WR_DATA[2])) // R15
		else $error("pull-up not following mode bit");

	// read, write and reset checks
	a_read_low: assert property (CAUSE_LO_RD // R7
		|=> RD_DATA == $past(hold_release_cause[3:0]))
		else $error("low cause nibble not returned");
	a_read_high: assert property (CAUSE_HI_RD && !CAUSE_LO_RD // R7
		|=> RD_DATA == $past(hold_release_cause[7:4]))
		else $error("high cause nibble not returned");
	a_enable_write: assert property (INT_EN_WR // R1
		|=> interrupt_enable_flags == ($past(WR_DATA) & ehw_pkg::EV_VALID))
		else $error("interrupt enables not written");
	a_reset_state: assert property ($fell(rst) // R13
		|-> PC_LOAD && PC_ADDR == ehw_pkg::PC_RESET_ADDR && PULLUP_EN == ehw_pkg::REG4_RESET)
		else $error("state after reset wrong");
	a_status_clear: assert property (CHG_CLR_OP && chg == ehw_pkg::REG4_RESET // R17
		|=> port_change_status == ehw_pkg::REG4_RESET)
		else $error("change status not cleared");

	// event, cause, hold and stop checks
	a_timer1_event: assert property (TM1_UDF |=> event_flags[ehw_pkg::EV_TM1]) // R10
		else $error("timer 1 event not flagged");
	a_cause_set: assert property ((event_flags & hold_release_enable) != ehw_pkg::REG8_RESET // R6
		|=> hold_release_cause != ehw_pkg::REG8_RESET)
		else $error("cause not loaded from enabled flag");
	a_hold_enter: assert property (state == ehw_pkg::ST_RUN && HOLD_OP && !STOP_OP // R8
		&& hold_release_cause == ehw_pkg::REG8_RESET |=> IN_HOLD)
		else $error("hold not entered with no cause");
	a_stop_enter: assert property (state == ehw_pkg::ST_RUN && STOP_OP |=> IN_STOP) // R18
		else $error("stop not entered");

	c_take_port: cover property (take && win_idx == 3'(ehw_pkg::EV_PORT));
	c_hold_isr_return: cover property (state == ehw_pkg::ST_HOLD_ISR ##[1:20] IN_HOLD);
	c_hold_release: cover property (IN_HOLD ##1 state == ehw_pkg::ST_RUN);
	c_stop_wake: cover property (IN_STOP ##1 !IN_STOP);
	c_cause_timer1: cover property (hold_release_cause[ehw_pkg::HC_TM1]);
endmodule // ehw_ctrl

// ---- testbench/ehw_pin_model.sv ----
// change-input pin model standing in front of the control block
// assumes the bench picks which pins it drives; loose pins float
`timescale 1ns/1ps
module ehw_pin_model (
	// clock and pull-up control from the block
	input wire logic clk,
	input wire logic [3:0] pullup_en,
	// bench drive
	input wire logic [3:0] drive_en,
	input wire logic [3:0] drive_val,
	// pins
	output logic [3:0] pins
);
	logic [3:0] last;
	// remember the level so a floating pin can wander
	always_ff @(posedge clk) begin
		last <= pins;
	end
	// a loose pin goes high with pull-up, else toggles each cycle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (drive_en[i]) begin
				pins[i] = drive_val[i];
			end else if (pullup_en[i]) begin
				pins[i] = 1'b1;
			end else begin
				pins[i] = ~last[i];
			end
		end
	end
endmodule // ehw_pin_model

// ---- testbench/event_hold_wakeup_control_bench.sv ----
// self-checking bench for the event, hold and wake-up control block
// assumes one 50 MHz clock; inputs move on the falling edge
`timescale 1ns/1ps
module event_hold_wakeup_control_bench;
	logic CLK = 1'b0;
	logic RESET_N, EXT_RESET_N;
	logic [7:0] WR_DATA;
	logic INT_EN_WR, HOLD_EN_WR, PORT_EN_WR, STOP_EN_WR, MODE_WR;
	logic EVT_CLR_OP, CHG_CLR_OP, INT_UNMASK_OP, INT_MASK_OP;
	logic HOLD_OP, STOP_OP, RETURN_OP, CAUSE_LO_RD, CAUSE_HI_RD, CHG_STAT_RD;
	logic DIV0_OVF, TM0_UDF, DIV1_OVF, TM1_UDF;
	logic [3:0] RD_DATA, CHANGE_IN, PULLUP_EN, pin_en, pin_val;
	logic INT_TAKE, PC_LOAD, IN_HOLD, IN_STOP;
	logic [11:0] PC_ADDR;
	int miscompares = 0;
	int checked = 0;
	ehw_ctrl ehw_ctrl_inst (.CLK(CLK), .RESET_N(RESET_N), .EXT_RESET_N(EXT_RESET_N),
		.WR_DATA(WR_DATA), .INT_EN_WR(INT_EN_WR), .HOLD_EN_WR(HOLD_EN_WR),
		.PORT_EN_WR(PORT_EN_WR), .STOP_EN_WR(STOP_EN_WR), .MODE_WR(MODE_WR),
		.EVT_CLR_OP(EVT_CLR_OP), .CHG_CLR_OP(CHG_CLR_OP), .INT_UNMASK_OP(INT_UNMASK_OP),
		.INT_MASK_OP(INT_MASK_OP), .HOLD_OP(HOLD_OP), .STOP_OP(STOP_OP),
		.RETURN_OP(RETURN_OP), .CAUSE_LO_RD(CAUSE_LO_RD), .CAUSE_HI_RD(CAUSE_HI_RD),
		.CHG_STAT_RD(CHG_STAT_RD), .RD_DATA(RD_DATA), .DIV0_OVF(DIV0_OVF),
		.TM0_UDF(TM0_UDF), .DIV1_OVF(DIV1_OVF), .TM1_UDF(TM1_UDF),
		.CHANGE_IN(CHANGE_IN), .INT_TAKE(INT_TAKE), .PC_LOAD(PC_LOAD),
		.PC_ADDR(PC_ADDR), .IN_HOLD(IN_HOLD), .IN_STOP(IN_STOP), .PULLUP_EN(PULLUP_EN));
	ehw_pin_model ehw_pin_model_inst (.clk(CLK), .pullup_en(PULLUP_EN),
		.drive_en(pin_en), .drive_val(pin_val), .pins(CHANGE_IN));
	// clock
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// verdict and end of run
	task automatic report_and_stop();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// compare one value
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// bounded wait for a level
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 12; i++) begin
			@(negedge CLK);
			if (s === v) return;
		end
		miscompares++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	// one-cycle strobe with operand
	task automatic op(ref logic s, input logic [7:0] d);
		@(negedge CLK);
		s = 1'b1;
		WR_DATA = d;
		@(negedge CLK);
		s = 1'b0;
	endtask
	// one-cycle event pulses {tm1,div1,tm0,div0}
	task automatic ev(input logic [3:0] e);
		@(negedge CLK);
		{TM1_UDF, DIV1_OVF, TM0_UDF, DIV0_OVF} = e;
		@(negedge CLK);
		{TM1_UDF, DIV1_OVF, TM0_UDF, DIV0_OVF} = 4'h0;
	endtask
	// read one nibble and compare
	task automatic rd(ref logic s, input logic [3:0] e);
		op(s, 8'h00);
		chk(RD_DATA, e);
	endtask
	// wait for a take and check its vector
	task automatic take(input logic [11:0] a);
		wt(INT_TAKE, 1'b1);
		chk(PC_ADDR, a);
		chk(PC_LOAD, 1'b1);
	endtask
	// no take for n cycles
	task automatic no_take(input int n);
		repeat (n) begin
			@(negedge CLK);
			chk(INT_TAKE, 1'b0);
		end
	endtask
	// reset by either source, then check cleared state
	task automatic sc_reset(input logic ext);
		if (ext) EXT_RESET_N = 1'b0;
		else RESET_N = 1'b0;
		repeat (3) @(negedge CLK);
		RESET_N = 1'b1;
		EXT_RESET_N = 1'b1;
		@(negedge CLK);
		chk(PC_LOAD, 1'b1);
		repeat (3) @(negedge CLK);
		chk(PC_LOAD, 1'b0);
		chk(PC_ADDR, 12'h000);
		chk(PULLUP_EN, 4'h0);
		chk({IN_HOLD, IN_STOP}, 2'h0);
		rd(CAUSE_LO_RD, 4'h0);
		rd(CHG_STAT_RD, 4'h0);
	endtask
	// take blocks further takes until enables rewritten
	task automatic sc_block();
		op(INT_EN_WR, 8'h02);
		ev(4'h2);
		take(12'h008);
		ev(4'h2);
		no_take(5);
		op(INT_EN_WR, 8'h02);
		take(12'h008);
	endtask
	// three at once: lowest first, others stay pending
	task automatic sc_prio();
		op(INT_EN_WR, 8'h91);
		ev(4'hD);
		take(12'h004);
		no_take(4);
		op(INT_UNMASK_OP, 8'h00);
		take(12'h014);
		op(INT_UNMASK_OP, 8'h00);
		take(12'h020);
	endtask
	// pin change interrupt, status and pull-ups
	task automatic sc_pins();
		op(PORT_EN_WR, 8'h01);
		op(MODE_WR, 8'h04);
		chk(PULLUP_EN, 4'hF);
		op(CHG_CLR_OP, 8'h00);
		op(INT_EN_WR, 8'h04);
		pin_val = 4'hE;
		take(12'h00C);
		rd(CHG_STAT_RD, 4'h1);
		op(CHG_CLR_OP, 8'h00);
		rd(CHG_STAT_RD, 4'h0);
	endtask
	// hold, interrupt in hold, release cause and its clearing
	task automatic sc_hold();
		op(HOLD_EN_WR, 8'h01);
		op(HOLD_OP, 8'h00);
		chk(IN_HOLD, 1'b1);
		op(INT_EN_WR, 8'h02);
		ev(4'h2);
		take(12'h008);
		chk(IN_HOLD, 1'b0);
		op(RETURN_OP, 8'h00);
		chk(IN_HOLD, 1'b1);
		ev(4'h1);
		wt(IN_HOLD, 1'b0);
		op(HOLD_OP, 8'h00);
		repeat (2) @(negedge CLK);
		chk(IN_HOLD, 1'b0);
		rd(CAUSE_LO_RD, 4'h1);
		rd(CAUSE_HI_RD, 4'h0);
		op(EVT_CLR_OP, 8'h01);
		rd(CAUSE_LO_RD, 4'h1);
		op(HOLD_EN_WR, 8'h00);
		rd(CAUSE_LO_RD, 4'h0);
		op(HOLD_EN_WR, 8'h80);
		ev(4'h8);
		rd(CAUSE_HI_RD, 4'h2);
		op(EVT_CLR_OP, 8'h80);
		op(HOLD_EN_WR, 8'h00);
	endtask
	// mask holds off takes until unmask
	task automatic sc_mask();
		op(INT_MASK_OP, 8'h00);
		op(INT_EN_WR, 8'h02);
		ev(4'h2);
		no_take(5);
		op(INT_UNMASK_OP, 8'h00);
		take(12'h008);
	endtask
	// stop ends only on a falling edge of an enabled pin
	task automatic sc_stop();
		op(STOP_EN_WR, 8'h01);
		op(STOP_OP, 8'h00);
		chk(IN_STOP, 1'b1);
		pin_en = 4'hE;
		repeat (6) @(negedge CLK);
		chk(IN_STOP, 1'b1);
		pin_en = 4'hF;
		wt(IN_STOP, 1'b0);
	endtask
	// main sequence
	initial begin
		{RESET_N, EXT_RESET_N, WR_DATA} = {2'b01, 8'h00};
		{INT_EN_WR, HOLD_EN_WR, PORT_EN_WR, STOP_EN_WR, MODE_WR} = 5'h00;
		{EVT_CLR_OP, CHG_CLR_OP, INT_UNMASK_OP, INT_MASK_OP} = 4'h0;
		{HOLD_OP, STOP_OP, RETURN_OP, CAUSE_LO_RD, CAUSE_HI_RD, CHG_STAT_RD} = 6'h00;
		{TM1_UDF, DIV1_OVF, TM0_UDF, DIV0_OVF} = 4'h0;
		pin_en = 4'hF;
		pin_val = 4'hF;
		sc_reset(1'b0);
		sc_block();
		sc_prio();
		sc_pins();
		sc_hold();
		sc_mask();
		sc_stop();
		sc_reset(1'b1);
		report_and_stop();
	end
endmodule // event_hold_wakeup_control_bench
